// ---- rtl/ccerr_cfg.svh ----
// Register offsets, field positions and reset values of the control channel
// error block. Assumes the 8-bit register address space of the hub's local
// serial target, which drives the read and write strobes.
`ifndef CCERR_CFG_SVH
`define CCERR_CFG_SVH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define CCERR_ADDR_ERR_CTL 8'h46
`define CCERR_ADDR_STATUS 8'h47
`define CCERR_ADDR_CAP 8'h4A
`define CCERR_ADDR_PORT_SEL 8'h4C

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define CCERR_BIT_SEQ 5
`define CCERR_BIT_CTRL_ERR 4
`define CCERR_BIT_CTRL_TO 3
`define CCERR_BIT_TGT_ERR 2
`define CCERR_BIT_TGT_TO 1
`define CCERR_BIT_RESP 0
`define CCERR_BIT_ENH 5
`define CCERR_BIT_ENC_CAP 4
`define CCERR_SEL_MSB 5

// -----------------------------------------------------------------------------
// Reset and fixed values
// -----------------------------------------------------------------------------
`define CCERR_RST_FLAGS 6'h00
`define CCERR_RST_ENH 1'b1
`define CCERR_RST_CAP 1'b0
`define CCERR_RST_SEL 6'h00
`define CCERR_PHYS_PORT_LOCAL 2'h0
`define CCERR_RSVD_STATUS 2'h0
`define CCERR_MAX_PORTS 4

`endif

// ---- rtl/ccerr_pkg.sv ----
// Types shared by the control channel error block.
// Assumes at most four receive ports, as the port select layout allows.
package ccerr_pkg;

   // --------------------------------------------------------------------------
   // Per-port events from the control channel engine
   // --------------------------------------------------------------------------
   typedef struct packed {
      logic seq_err;
      logic crc_err;
      logic lock_err;
      logic ctrl_wait;
      logic tgt_wait;
      logic wdog_expire;
      logic resp_err;
      logic sts1_seq;
      logic enc_crc_err;
   } ccerr_evt_t;

   // --------------------------------------------------------------------------
   // Register request from the local serial target
   // --------------------------------------------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ccerr_req_t;

   // --------------------------------------------------------------------------
   // Port select register layout
   // --------------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] rd_port;
      logic [3:0] wr_en;
   } ccerr_sel_t;

endpackage

// ---- rtl/ccerr_top.sv ----
// Per-port control channel error status and link capability registers.
// Assumes a local serial target that issues single-cycle read and write
// strobes, and a channel engine that reports error events as one-cycle pulses.
`timescale 1ns/1ps
`include "ccerr_cfg.svh"

module ccerr_top #(
   parameter int NPORT = 4
) (
   // Clock, reset and freeze
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // Register access
   input wire ccerr_pkg::ccerr_req_t i_req,
   output logic [7:0] o_rdata,
   output logic o_rd_valid,
   // Channel engine events, one entry per receive port
   input wire ccerr_pkg::ccerr_evt_t [NPORT-1:0] i_evt,
   // Controls back to the channel engine
   output logic [NPORT-1:0] o_enh_check_en,
   output logic [NPORT-1:0] o_enc_crc_flag
);
   import ccerr_pkg::*;

   // --------------------------------------------------------------------------
   // Elaboration check
   // --------------------------------------------------------------------------
   // Port select carries a two-bit read port and four write enables
   if (NPORT < 1 || NPORT > `CCERR_MAX_PORTS) begin : g_bad_nport
      $error("NPORT must lie between 1 and 4");
   end

   // --------------------------------------------------------------------------
   // Decoding helpers
   // --------------------------------------------------------------------------
   function automatic logic is_rd(input ccerr_req_t r, input logic [7:0] a);
      return r.rd && (r.addr == a);
   endfunction

   function automatic logic is_wr(input ccerr_req_t r, input logic [7:0] a);
      return r.wr && (r.addr == a);
   endfunction

   function automatic logic fwd_err(input ccerr_evt_t e);
      return e.seq_err | e.crc_err | e.lock_err;
   endfunction

   // --------------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------------
   logic [5:0] flag_q [NPORT];
   logic [5:0] flag_d [NPORT];
   logic [5:0] set_v [NPORT];
   logic [NPORT-1:0] clr_hit;
   logic [NPORT-1:0] enh_q;
   logic [NPORT-1:0] enh_d;
   logic [NPORT-1:0] cap_q;
   logic [NPORT-1:0] cap_d;
   logic [NPORT-1:0] encf_q;
   logic [NPORT-1:0] encf_d;
   ccerr_sel_t sel_q;
   ccerr_sel_t sel_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic rvld_q;
   logic rvld_d;

   // --------------------------------------------------------------------------
   // Error flags
   // --------------------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         set_v[p] = '0;
         if (enh_q[p]) begin
            set_v[p][`CCERR_BIT_SEQ] = i_evt[p].seq_err;
            set_v[p][`CCERR_BIT_CTRL_ERR] = i_evt[p].ctrl_wait & fwd_err(i_evt[p]);
            set_v[p][`CCERR_BIT_CTRL_TO] = i_evt[p].ctrl_wait & i_evt[p].wdog_expire;
            set_v[p][`CCERR_BIT_TGT_ERR] = i_evt[p].tgt_wait & fwd_err(i_evt[p]);
            set_v[p][`CCERR_BIT_RESP] = i_evt[p].resp_err;
         end
         // Target timeout is reported whatever the enhanced setting
         set_v[p][`CCERR_BIT_TGT_TO] = i_evt[p].tgt_wait & i_evt[p].wdog_expire;
         clr_hit[p] = is_rd(i_req, `CCERR_ADDR_STATUS) && (int'(sel_q.rd_port) == p);
         flag_d[p] = flag_q[p];
         if (clr_hit[p]) begin
            flag_d[p] = '0;
         end
         // Set after clear, so an event in the read cycle survives
         flag_d[p] = flag_d[p] | set_v[p];
         if (!enh_q[p]) begin
            flag_d[p][`CCERR_BIT_SEQ] = i_evt[p].sts1_seq;
            flag_d[p][`CCERR_BIT_CTRL_ERR] = 1'b0;
            flag_d[p][`CCERR_BIT_CTRL_TO] = 1'b0;
            flag_d[p][`CCERR_BIT_TGT_ERR] = 1'b0;
            flag_d[p][`CCERR_BIT_RESP] = 1'b0;
         end
      end
   end

   // --------------------------------------------------------------------------
   // Control and capability registers
   // --------------------------------------------------------------------------
   always_comb begin
      sel_d = sel_q;
      if (is_wr(i_req, `CCERR_ADDR_PORT_SEL)) begin
         sel_d = ccerr_sel_t'(i_req.wdata[`CCERR_SEL_MSB:0]);
      end
      for (int p = 0; p < NPORT; p++) begin
         enh_d[p] = enh_q[p];
         cap_d[p] = cap_q[p];
         // Broadcast write: every enabled port takes the same byte
         if (is_wr(i_req, `CCERR_ADDR_ERR_CTL) && sel_q.wr_en[p]) begin
            enh_d[p] = i_req.wdata[`CCERR_BIT_ENH];
         end
         if (is_wr(i_req, `CCERR_ADDR_CAP) && sel_q.wr_en[p]) begin
            cap_d[p] = i_req.wdata[`CCERR_BIT_ENC_CAP];
         end
         encf_d[p] = i_evt[p].enc_crc_err & cap_q[p];
      end
   end

   // --------------------------------------------------------------------------
   // Read data
   // --------------------------------------------------------------------------
   always_comb begin
      rvld_d = i_req.rd;
      rdata_d = '0;
      if (is_rd(i_req, `CCERR_ADDR_PORT_SEL)) begin
         rdata_d = {`CCERR_PHYS_PORT_LOCAL, sel_q};
      end
      for (int p = 0; p < NPORT; p++) begin
         if (i_req.rd && (int'(sel_q.rd_port) == p)) begin
            if (i_req.addr == `CCERR_ADDR_STATUS) begin
               rdata_d = {`CCERR_RSVD_STATUS, flag_q[p]};
            end
            if (i_req.addr == `CCERR_ADDR_ERR_CTL) begin
               rdata_d[`CCERR_BIT_ENH] = enh_q[p];
            end
            if (i_req.addr == `CCERR_ADDR_CAP) begin
               rdata_d[`CCERR_BIT_ENC_CAP] = cap_q[p];
            end
         end
      end
   end

   // --------------------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         for (int p = 0; p < NPORT; p++) begin
            flag_q[p] <= `CCERR_RST_FLAGS;
         end
         enh_q <= {NPORT{`CCERR_RST_ENH}};
         cap_q <= {NPORT{`CCERR_RST_CAP}};
         encf_q <= '0;
         sel_q <= ccerr_sel_t'(`CCERR_RST_SEL);
         rdata_q <= '0;
         rvld_q <= 1'b0;
      end else if (i_ce) begin
         for (int p = 0; p < NPORT; p++) begin
            flag_q[p] <= flag_d[p];
         end
         enh_q <= enh_d;
         cap_q <= cap_d;
         encf_q <= encf_d;
         sel_q <= sel_d;
         rdata_q <= rdata_d;
         rvld_q <= rvld_d;
      end
   end

   assign o_rdata = rdata_q;
   assign o_rd_valid = rvld_q;
   // The engine stops detecting and terminating on errors while this is low
   assign o_enh_check_en = enh_q;
   assign o_enc_crc_flag = encf_q;

   // --------------------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);

   for (genvar g = 0; g < NPORT; g++) begin : g_chk
      AST_RD_PORT:
      assert property (i_ce && is_rd(i_req, `CCERR_ADDR_STATUS)
         && int'(sel_q.rd_port) == g
         |=> o_rd_valid && o_rdata == {`CCERR_RSVD_STATUS, $past(flag_q[g])})
      else $error("Status read returned wrong port copy");

      AST_WR_GATED:
      assert property (i_ce && is_wr(i_req, `CCERR_ADDR_ERR_CTL) && !sel_q.wr_en[g]
         |=> $stable(enh_q[g]))
      else $error("Write reached a port whose write enable is off");

      AST_SEQ_SET:
      assert property (i_ce && enh_q[g] && i_evt[g].seq_err
         |=> flag_q[g][`CCERR_BIT_SEQ])
      else $error("Sequence error not latched");

      AST_SEQ_MIRROR:
      assert property (i_ce && !enh_q[g]
         |=> flag_q[g][`CCERR_BIT_SEQ] == $past(i_evt[g].sts1_seq))
      else $error("Sequence bit does not mirror port status");

      AST_SEQ_CLR:
      assert property (i_ce && enh_q[g] && clr_hit[g] && !i_evt[g].seq_err
         |=> !flag_q[g][`CCERR_BIT_SEQ])
      else $error("Sequence flag not cleared by status read");

      AST_CTRL_ERR:
      assert property (i_ce && enh_q[g] && i_evt[g].ctrl_wait && i_evt[g].lock_err
         |=> flag_q[g][`CCERR_BIT_CTRL_ERR])
      else $error("Controller wait error not latched");

      AST_CTRL_TO:
      assert property (i_ce && enh_q[g] && i_evt[g].ctrl_wait && i_evt[g].wdog_expire
         |=> flag_q[g][`CCERR_BIT_CTRL_TO])
      else $error("Controller wait timeout not latched");

      AST_TGT_ERR:
      assert property (i_ce && enh_q[g] && i_evt[g].tgt_wait && i_evt[g].crc_err
         |=> flag_q[g][`CCERR_BIT_TGT_ERR])
      else $error("Target wait error not latched");

      AST_TGT_TO_HOLD:
      assert property (i_ce && i_evt[g].tgt_wait && i_evt[g].wdog_expire
         ##1 (!i_ce || !clr_hit[g])
         |=> flag_q[g][`CCERR_BIT_TGT_TO])
      else $error("Target wait timeout flag lost before a read");

      AST_RESP:
      assert property (i_ce && enh_q[g] && i_evt[g].resp_err
         |=> flag_q[g][`CCERR_BIT_RESP])
      else $error("Response error not latched");

      AST_NO_ENH:
      assert property (i_ce && !enh_q[g]
         |=> !flag_q[g][`CCERR_BIT_CTRL_ERR] && !flag_q[g][`CCERR_BIT_RESP]
            && !flag_q[g][`CCERR_BIT_TGT_ERR] && !flag_q[g][`CCERR_BIT_CTRL_TO])
      else $error("Enhanced-only flag set while checking is off");

      AST_ENC_FLAG:
      assert property (i_ce && i_evt[g].enc_crc_err
         |=> o_enc_crc_flag[g] == $past(cap_q[g]))
      else $error("Encoder CRC flag ignores capability bit");

      AST_ENH_RESET:
      assert property ($rose(i_nrst) |-> o_enh_check_en[g])
      else $error("Enhanced checking not enabled after reset");

      AST_SET_WINS:
      assert property (i_ce && clr_hit[g] && i_evt[g].tgt_wait && i_evt[g].wdog_expire
         |=> flag_q[g][`CCERR_BIT_TGT_TO])
      else $error("Event lost in the cycle of its clearing read");

      // A read with no new event must leave each flag but the sequence bit low
      AST_CTRL_ERR_CLR:
      assert property (i_ce && clr_hit[g] && !(i_evt[g].ctrl_wait && fwd_err(i_evt[g]))
         |=> !flag_q[g][`CCERR_BIT_CTRL_ERR])
      else $error("Controller wait error survived a status read");

      AST_CTRL_TO_CLR:
      assert property (i_ce && clr_hit[g] && !(i_evt[g].ctrl_wait && i_evt[g].wdog_expire)
         |=> !flag_q[g][`CCERR_BIT_CTRL_TO])
      else $error("Controller wait timeout survived a status read");

      AST_TGT_ERR_CLR:
      assert property (i_ce && clr_hit[g] && !(i_evt[g].tgt_wait && fwd_err(i_evt[g]))
         |=> !flag_q[g][`CCERR_BIT_TGT_ERR])
      else $error("Target wait error survived a status read");

      AST_TGT_TO_CLR:
      assert property (i_ce && clr_hit[g] && !(i_evt[g].tgt_wait && i_evt[g].wdog_expire)
         |=> !flag_q[g][`CCERR_BIT_TGT_TO])
      else $error("Target wait timeout survived a status read");

      AST_RESP_CLR:
      assert property (i_ce && clr_hit[g] && !i_evt[g].resp_err
         |=> !flag_q[g][`CCERR_BIT_RESP])
      else $error("Response error survived a status read");

      AST_CAP_WRITE:
      assert property (i_ce && is_wr(i_req, `CCERR_ADDR_CAP) && sel_q.wr_en[g]
         |=> cap_q[g] == $past(i_req.wdata[`CCERR_BIT_ENC_CAP]))
      else $error("Capability write did not reach an enabled port");

      AST_ENC_QUIET:
      assert property (i_ce && !i_evt[g].enc_crc_err
         |=> !o_enc_crc_flag[g])
      else $error("Encoder CRC flag raised without an event");

      AST_ENH_WRITE:
      assert property (i_ce && is_wr(i_req, `CCERR_ADDR_ERR_CTL) && sel_q.wr_en[g]
         |=> o_enh_check_en[g] == $past(i_req.wdata[`CCERR_BIT_ENH]))
      else $error("Enable write did not reach an enabled port");
   end

   AST_SEL_WRITE:
   assert property (i_ce && is_wr(i_req, `CCERR_ADDR_PORT_SEL)
      |=> sel_q == $past(i_req.wdata[`CCERR_SEL_MSB:0]))
   else $error("Port select write not taken");

endmodule

// ---- tb/ccerr_evt_model.sv ----
// Behavioural model of the channel engine that reports serializer events.
// Assumes the bench calls its tasks; events are driven just after an edge.
`timescale 1ns/1ps

module ccerr_evt_model #(
   parameter int NPORT = 4
) (
   // Clock
   input wire logic i_core_clk,
   // Events toward the block
   output ccerr_pkg::ccerr_evt_t [NPORT-1:0] o_evt
);
   import ccerr_pkg::*;

   logic [NPORT-1:0] sts1_lvl;

   initial begin
      o_evt = '0;
      sts1_lvl = '0;
   end

   // -------------------------------------------------------------------------
   // Event pulse, optionally late to mimic a slow serializer answer
   // -------------------------------------------------------------------------
   task automatic pulse(input int p, input ccerr_evt_t e, input int lag);
      ccerr_evt_t ev;
      ev = e;
      ev.sts1_seq = sts1_lvl[p];
      repeat (lag) @(posedge i_core_clk);
      @(posedge i_core_clk);
      o_evt[p] <= ev;
      // Back to idle but the status level stays as it was
      ev = '0;
      ev.sts1_seq = sts1_lvl[p];
      @(posedge i_core_clk);
      o_evt[p] <= ev;
   endtask

   // Sequence bit of the port status register is a level, not a pulse
   task automatic set_sts1(input int p, input logic v);
      @(posedge i_core_clk);
      sts1_lvl[p] = v;
      o_evt[p].sts1_seq <= v;
   endtask

endmodule

// ---- tb/ccerr_top_tb.sv ----
// Self-checking bench for the control channel error registers.
// Assumes single-cycle read and write strobes from the local serial target.
`timescale 1ns/1ps

module ccerr_top_tb;
   import ccerr_pkg::*;

   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic ce = 1'b1;
   ccerr_req_t req = '0;
   logic [7:0] rdata;
   logic rd_valid;
   ccerr_evt_t [3:0] evt;
   logic [3:0] enh;
   logic [3:0] encf;
   int bad_count = 0;
   int num_checks = 0;
   logic [8:0] ev_tab [7] = '{9'h100, 9'h120, 9'h060, 9'h028, 9'h090, 9'h018, 9'h004};
   logic [7:0] ex_tab [7] = '{8'h20, 8'h30, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};

   always #5 i_core_clk = ~i_core_clk;

   ccerr_top #(.NPORT(4)) u_dut (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_ce(ce),
      .i_req(req),
      .o_rdata(rdata),
      .o_rd_valid(rd_valid),
      .i_evt(evt),
      .o_enh_check_en(enh),
      .o_enc_crc_flag(encf)
   );

   ccerr_evt_model #(.NPORT(4)) u_model (
      .i_core_clk(i_core_clk),
      .o_evt(evt)
   );

   // -------------------------------------------------------------------------
   // Register access and comparison
   // -------------------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      req <= {1'b0, 1'b1, a, d};
      @(posedge i_core_clk);
      req.wr <= 1'b0;
   endtask

   // Answer is registered at the edge that takes the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_core_clk);
      req <= {1'b1, 1'b0, a, 8'h00};
      @(posedge i_core_clk);
      req.rd <= 1'b0;
      #1;
      check({7'h00, rd_valid}, 8'h01);
      check(rdata, exp);
   endtask

   task automatic summarize;
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge i_core_clk);
      bad_count++;
      summarize();
   end

   // -------------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------------
   initial begin
      repeat (12) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      #1;
      check({4'h0, enh}, 8'h0F);
      rd(8'h46, 8'h20);
      rd(8'h47, 8'h00);
      rd(8'h4A, 8'h00);
      rd(8'h4C, 8'h00);
      rd(8'h50, 8'h00);
      wr(8'h4C, 8'h0F);
      rd(8'h4C, 8'h0F);
      // Capability bit set in all ports, as software is expected to do
      wr(8'h4A, 8'h10);
      rd(8'h4A, 8'h10);
      wr(8'h47, 8'h3F);
      rd(8'h47, 8'h00);
      // Port 0 alone loses enhanced checking
      wr(8'h4C, 8'h01);
      wr(8'h46, 8'h00);
      @(posedge i_core_clk);
      #1;
      check({4'h0, enh}, 8'h0E);
      rd(8'h46, 8'h00);
      wr(8'h4C, 8'h10);
      rd(8'h46, 8'h20);
      for (int i = 0; i < 7; i++) begin
         u_model.pulse(1, ev_tab[i], (i % 2) * 3);
         rd(8'h47, ex_tab[i]);
         rd(8'h47, 8'h00);
      end
      // Event lands in the very cycle the read is taken
      fork
         rd(8'h47, 8'h00);
         u_model.pulse(1, 9'h118, 0);
      join
      rd(8'h47, 8'h26);
      rd(8'h47, 8'h00);
      // Port 0 with enhanced checking off
      wr(8'h4C, 8'h00);
      u_model.set_sts1(0, 1'b1);
      u_model.pulse(0, 9'h0BC, 0);
      rd(8'h47, 8'h22);
      rd(8'h47, 8'h20);
      u_model.set_sts1(0, 1'b0);
      repeat (2) @(posedge i_core_clk);
      rd(8'h47, 8'h00);
      // Encoder CRC flag gated by the capability bit of port 1
      wr(8'h4C, 8'h12);
      u_model.pulse(1, 9'h001, 0);
      #1;
      check({4'h0, encf}, 8'h02);
      wr(8'h4A, 8'h00);
      u_model.pulse(1, 9'h001, 0);
      #1;
      check({4'h0, encf}, 8'h00);
      rd(8'h4A, 8'h00);
      // Frozen clock enable: an event seen while it is low is lost
      @(posedge i_core_clk);
      ce <= 1'b0;
      u_model.pulse(1, 9'h100, 0);
      ce <= 1'b1;
      rd(8'h47, 8'h00);
      // Mid-run reset returns every port to its defaults
      u_model.pulse(0, 9'h018, 0);
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      #1;
      check({4'h0, enh}, 8'h0F);
      rd(8'h4C, 8'h00);
      rd(8'h47, 8'h00);
      summarize();
   end

endmodule
